// [dv/idfss_bench.sv]
`timescale 1ns/1ns
module i2c_dma_filter_slave_setup_bench;
    import idfss_pkg::*;
    logic        clock;
    logic        reset_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        dma_tx_eot, dma_rx_eot, dma_tx_valid;
    logic [7:0]  dma_tx_data, sent;
    logic        dma_tx_ready, dma_tx_req, dma_rx_req;
    logic        rx_pending, stretch_release, tx_ready, tx_valid;
    logic [7:0]  tx_data;
    logic        force_stop, setup_busy, setup_done;
    logic [9:0]  own_address;
    logic        sda_in, scl_in, sda_filt, scl_filt, go;
    logic [31:0] d;
    int          fails, total_checks, exp_byte, n;
    logic [2:0]  fw [4];

    idfss_top u_dut (.clock(clock), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .dma_tx_eot(dma_tx_eot), .dma_rx_eot(dma_rx_eot),
        .dma_tx_valid(dma_tx_valid), .dma_tx_data(dma_tx_data),
        .dma_tx_ready(dma_tx_ready), .dma_tx_req(dma_tx_req),
        .dma_rx_req(dma_rx_req), .rx_pending(rx_pending),
        .stretch_release(stretch_release), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .force_stop(force_stop),
        .own_address(own_address), .setup_busy(setup_busy),
        .setup_done(setup_done), .sda_in(sda_in), .scl_in(scl_in),
        .sda_filt(sda_filt), .scl_filt(scl_filt));

    idfss_dma_model #(.N(40)) u_dma (.clock(clock), .reset_n(reset_n),
        .go(go), .sent(sent), .dma_tx_ready(dma_tx_ready),
        .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
        .dma_tx_valid(dma_tx_valid), .dma_tx_data(dma_tx_data),
        .dma_tx_eot(dma_tx_eot), .dma_rx_eot(dma_rx_eot));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ==========================================================
    // checks and bus tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        v = rdata;
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] v,
                         output logic [31:0] q);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        q = rdata;
    endtask

    // bounded wait on the negedge; running out ends the run
    task automatic give_up(input int cnt, input int lim);
        if (cnt >= lim) begin
            chk(32'(cnt), 32'(lim - 1));
            final_report();
        end
    endtask

    task automatic setup_run(input logic [15:0] v);
        int b;
        wr_reg(IDFSS_SCTL_ADDR, {v, 16'h02aa});
        @(posedge clock);
        stretch_release <= 1'b1;
        @(posedge clock);
        stretch_release <= 1'b0;
        n = 1;
        b = 0;
        @(negedge clock);
        while (setup_done !== 1'b1 && n < 40) begin
            if (setup_busy === 1'b1) b++;
            @(negedge clock);
            n++;
        end
        give_up(n, 40);
        chk(32'(n), (v > 1) ? 32'(v) : 32'h1);
        chk(32'(b), (v > 1) ? 32'(v - 1) : 32'h0);
        @(negedge clock);
        chk({31'h0, setup_done}, 32'h0);
    endtask

    // low pulse of len cycles on both lines, watch both filter outputs
    task automatic glitch(input int len, input logic pass);
        logic ss, sc;
        ss = 1'b0;
        sc = 1'b0;
        for (int i = 0; i < len + 12; i++) begin
            @(posedge clock);
            if (i == 0) {sda_in, scl_in} <= 2'b00;
            if (i == len) {sda_in, scl_in} <= 2'b11;
            @(negedge clock);
            ss |= (sda_filt === 1'b0);
            sc |= (scl_filt === 1'b0);
        end
        chk({31'h0, ss}, {31'h0, pass});
        chk({31'h0, sc}, {31'h0, pass});
        chk({30'h0, sda_filt, scl_filt}, 32'h3);
    endtask

    // ==========================================================
    // tx stream order at the consumer
    always @(posedge clock) begin
        if (reset_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk({24'h0, tx_data}, 32'(exp_byte));
            exp_byte++;
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        fw = '{IDFSS_FW_NONE, IDFSS_FW_ONE, IDFSS_FW_TWO, IDFSS_FW_FOUR};
        {reset_n, wr, rd, rx_pending, stretch_release, tx_ready} = 6'h0;
        {addr, wdata, go, exp_byte, fails, total_checks} = '0;
        {sda_in, scl_in} = 2'b11;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rd_reg(IDFSS_SCTL_ADDR, d);
        chk(d, 32'h000f0055);
        chk({22'h0, own_address}, 32'h55);
        rd_reg(IDFSS_MCTL_ADDR, d);
        chk(d, 32'h0);
        rd_reg(IDFSS_STAT_ADDR, d);
        chk(d, 32'h3);
        rd_reg(8'h20, d);
        chk(d, 32'h0);
        wr_rd(IDFSS_SCTL_ADDR, 32'h000502aa, d);
        chk(d, 32'h000502aa);
        chk({22'h0, own_address}, 32'h2aa);
        setup_run(16'h5);
        setup_run(16'h3);
        setup_run(16'h2);
        setup_run(16'h1);
        // force stop: pulse per write of one, none for zero
        wr_reg(IDFSS_MCTL_ADDR, 32'h8000);
        @(negedge clock);
        chk({31'h0, force_stop}, 32'h1);
        @(negedge clock);
        chk({31'h0, force_stop}, 32'h0);
        rd_reg(IDFSS_MCTL_ADDR, d);
        chk(d, 32'h8000);
        wr_reg(IDFSS_MCTL_ADDR, 32'h0);
        @(negedge clock);
        chk({31'h0, force_stop}, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr_rd(IDFSS_MCTL_ADDR, 32'(c) << 13, d);
            chk(d, 32'(c) << 13);
            if (fw[c] != 3'h0) glitch(int'(fw[c]), 1'b0);
            glitch(int'(fw[c]) + 1, 1'b1);
        end
        // tx dma: fill with consumer stalled, then drain to eot
        wr_reg(IDFSS_MCTL_ADDR, 32'h200);
        @(negedge clock);
        chk({31'h0, dma_tx_req}, 32'h1);
        go <= 1'b1;
        n = 0;
        while (dma_tx_ready !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        give_up(n, 100);
        repeat (5) @(negedge clock);
        chk({24'h0, sent}, 32'd33);
        rd_reg(IDFSS_STAT_ADDR, d);
        chk(d, 32'h1b);
        @(posedge clock);
        tx_ready <= 1'b1;
        n = 0;
        while (exp_byte < 40 && n < 300) begin
            @(negedge clock);
            n++;
        end
        give_up(n, 300);
        repeat (3) @(negedge clock);
        chk({31'h0, dma_tx_req}, 32'h0);
        rd_reg(IDFSS_MCTL_ADDR, d);
        chk(d, 32'h0);
        rd_reg(IDFSS_STAT_ADDR, d);
        chk(d, 32'h3);
        // rx dma alone, never together with tx
        wr_rd(IDFSS_MCTL_ADDR, 32'h400, d);
        chk(d, 32'h400);
        chk({31'h0, dma_rx_req}, 32'h0);
        @(posedge clock);
        rx_pending <= 1'b1;
        n = 0;
        while (dma_rx_req !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        give_up(n, 8);
        repeat (4) @(negedge clock);
        chk({31'h0, dma_rx_req}, 32'h0);
        rd_reg(IDFSS_MCTL_ADDR, d);
        chk(d, 32'h0);
        @(posedge clock);
        rx_pending <= 1'b0;
        final_report();
    end
endmodule

// [dv/idfss_dma_model.sv]
`timescale 1ns/1ns
module idfss_dma_model #(
    parameter int N = 40
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // bench control
    input  wire logic       go,
    output logic [7:0]      sent,
    // dma handshake
    input  wire logic       dma_tx_ready,
    input  wire logic       dma_tx_req,
    input  wire logic       dma_rx_req,
    output logic            dma_tx_valid,
    output logic [7:0]      dma_tx_data,
    output logic            dma_tx_eot,
    output logic            dma_rx_eot
);
    logic       valid_r;
    logic [7:0] data_r;
    logic [7:0] sent_r;
    logic       txe_r;
    logic       rxe_r;
    wire        taken = valid_r & dma_tx_ready & dma_tx_req;
    wire        last  = (int'(sent_r) == N - 1);

    assign dma_tx_valid = valid_r;
    assign dma_tx_data  = data_r;
    assign dma_tx_eot   = txe_r;
    assign dma_rx_eot   = rxe_r;
    assign sent         = sent_r;

    // ==========================================================
    // word source, offers back to back, holds until taken
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            valid_r <= 1'b0;
            data_r  <= 8'h00;
            sent_r  <= 8'h00;
            txe_r   <= 1'b0;
            rxe_r   <= 1'b0;
        end else begin
            txe_r <= taken & last;
            rxe_r <= dma_rx_req & ~rxe_r;
            if (taken) begin
                sent_r  <= sent_r + 8'h01;
                valid_r <= ~last;
                data_r  <= last ? ~data_r : sent_r + 8'h01;
            end else if (!valid_r && go && dma_tx_req
                         && int'(sent_r) < N) begin
                valid_r <= 1'b1;
                data_r  <= sent_r;
            end else if (!valid_r) begin
                // released data must not look like the last word
                data_r <= ~data_r;
            end
        end
    end
endmodule

// [hw/idfss_fifo.sv]
`timescale 1ns/1ns
module idfss_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         reset_n,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          rdy_r;
    logic          oval_r;
    logic [W-1:0]  odat_r;

    // ==========================================================
    // handshakes
    wire push = in_valid & rdy_r;
    wire pop  = (cnt_r != '0) & (~oval_r | out_ready);
    assign cnt_nxt   = cnt_r + CW'(push) - CW'(pop);
    assign in_ready  = rdy_r;
    assign out_valid = oval_r;
    assign out_data  = odat_r;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // ready is a flop so the source sees an honest full
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wp_r   <= '0;
            rp_r   <= '0;
            cnt_r  <= '0;
            rdy_r  <= 1'b1;
            oval_r <= 1'b0;
            odat_r <= '0;
        end else begin
            wp_r  <= push ? wp_r + AW'(1) : wp_r;
            rp_r  <= pop ? rp_r + AW'(1) : rp_r;
            cnt_r <= cnt_nxt;
            rdy_r <= (cnt_nxt != CW'(D));
            if (pop) begin
                oval_r <= 1'b1;
                odat_r <= mem_r[rp_r];
            end else if (out_ready) begin
                oval_r <= 1'b0;
            end
        end
    end
endmodule

// [hw/idfss_glitch.sv]
`timescale 1ns/1ns
module idfss_glitch (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // control
    input  wire logic [2:0] width,
    // line
    input  wire logic       line_in,
    output logic            line_out
);
    logic       out_r;
    logic [2:0] cnt_r;

    wire differ = (line_in != out_r);
    wire pass   = differ & (cnt_r >= width);
    assign line_out = out_r;

    // a level must outlast the width before it is taken
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_r <= 1'b1;
            cnt_r <= '0;
        end else begin
            out_r <= pass ? line_in : out_r;
            cnt_r <= (differ & ~pass) ? cnt_r + 3'h1 : 3'h0;
        end
    end
endmodule

// [hw/idfss_pkg.sv]
// Operation
// - bit 10 runs the receive DMA interface
// - DMA end of transfer clears transmit enable
// - DMA end of transfer clears receive enable
// - bits 14:13 select SDA/SCL spike filters
// - filter codes: none, 1, 2, 4 clocks
// - writing bit 15 high forces a STOP
// - own address low bits 6:0, reset 0x55
// - bits 9:7 extend address in 10-bit mode
// - setup wait is the programmed value in clocks, one at least
package idfss_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] IDFSS_MCTL_ADDR = 8'h00;
    localparam logic [7:0] IDFSS_SCTL_ADDR = 8'h04;
    localparam logic [7:0] IDFSS_STAT_ADDR = 8'h08;

    // ==========================================================
    // field positions
    localparam int IDFSS_TXEN_BIT   = 9;
    localparam int IDFSS_RXEN_BIT   = 10;
    localparam int IDFSS_FILT_LSB   = 13;
    localparam int IDFSS_FSTOP_BIT  = 15;
    localparam int IDFSS_ALO_LSB    = 0;
    localparam int IDFSS_AHI_LSB    = 7;
    localparam int IDFSS_SETUP_LSB  = 16;
    localparam int IDFSS_ST_SDA     = 0;
    localparam int IDFSS_ST_SCL     = 1;
    localparam int IDFSS_ST_BUSY    = 2;
    localparam int IDFSS_ST_FULL    = 3;
    localparam int IDFSS_ST_TXVAL   = 4;

    // ==========================================================
    // reset values and sizes
    localparam logic [6:0]  IDFSS_ALO_RST   = 7'h55;
    localparam logic [15:0] IDFSS_SETUP_RST = 16'h000f;
    localparam int          IDFSS_DATA_W    = 8;
    localparam int          IDFSS_FIFO_D    = 32;

    // spike widths in clock cycles per filter code
    localparam logic [2:0] IDFSS_FW_NONE = 3'h0;
    localparam logic [2:0] IDFSS_FW_ONE  = 3'h1;
    localparam logic [2:0] IDFSS_FW_TWO  = 3'h2;
    localparam logic [2:0] IDFSS_FW_FOUR = 3'h4;

    // ==========================================================
    // types
    typedef struct packed {
        logic       force_stop_request;
        logic [1:0] line_filter_select;
        logic       rx_dma_en;
        logic       tx_dma_en;
    } idfss_mctl_t;

    typedef struct packed {
        logic [15:0] slave_setup_delay;
        logic [2:0]  own_address_high;
        logic [6:0]  own_address_low;
    } idfss_sctl_t;

    typedef enum logic {
        IDFSS_SU_IDLE,
        IDFSS_SU_COUNT
    } idfss_su_t;

endpackage

// [hw/idfss_top.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module idfss_top
    import idfss_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // dma
    input  wire logic        dma_tx_eot,
    input  wire logic        dma_rx_eot,
    input  wire logic        dma_tx_valid,
    input  wire logic [7:0]  dma_tx_data,
    output logic             dma_tx_ready,
    output logic             dma_tx_req,
    output logic             dma_rx_req,
    // controller side
    input  wire logic        rx_pending,
    input  wire logic        stretch_release,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             force_stop,
    output logic [9:0]       own_address,
    output logic             setup_busy,
    output logic             setup_done,
    // bus pins, read side only
    input  wire logic        sda_in,
    input  wire logic        scl_in,
    output logic             sda_filt,
    output logic             scl_filt
);
    idfss_mctl_t mctl_r;
    idfss_sctl_t sctl_r;
    logic [31:0] rdata_r;
    logic        fstop_r;
    logic        rxreq_r;
    logic        sda_meta_r;
    logic        sda_sync_r;
    logic        scl_meta_r;
    logic        scl_sync_r;
    idfss_su_t   su_r;
    idfss_su_t   su_nxt;
    logic [15:0] su_cnt_r;
    logic [15:0] su_cnt_nxt;
    logic        busy_r;
    logic        done_r;
    logic        fifo_full_n;
    logic [2:0]  fwidth;

    // ==========================================================
    // helpers
    function automatic logic [31:0] mctl_pack(idfss_mctl_t m);
        logic [31:0] w;
        w = '0;
        w[IDFSS_TXEN_BIT]                 = m.tx_dma_en;
        w[IDFSS_RXEN_BIT]                 = m.rx_dma_en;
        w[IDFSS_FILT_LSB+:2]              = m.line_filter_select;
        w[IDFSS_FSTOP_BIT]                = m.force_stop_request;
        return w;
    endfunction

    function automatic logic [31:0] sctl_pack(idfss_sctl_t s);
        logic [31:0] w;
        w = '0;
        w[IDFSS_ALO_LSB+:7]    = s.own_address_low;
        w[IDFSS_AHI_LSB+:3]    = s.own_address_high;
        w[IDFSS_SETUP_LSB+:16] = s.slave_setup_delay;
        return w;
    endfunction

    function automatic logic [2:0] filt_width(logic [1:0] sel);
        logic [2:0] w;
        w = IDFSS_FW_NONE;
        case (sel)
            2'h1:    w = IDFSS_FW_ONE;
            2'h2:    w = IDFSS_FW_TWO;
            2'h3:    w = IDFSS_FW_FOUR;
            default: w = IDFSS_FW_NONE;
        endcase
        return w;
    endfunction

    // ==========================================================
    // register decode
    wire hit_mctl = (addr == IDFSS_MCTL_ADDR);
    wire hit_sctl = (addr == IDFSS_SCTL_ADDR);
    wire hit_stat = (addr == IDFSS_STAT_ADDR);
    wire wr_mctl  = wr & hit_mctl;
    wire wr_sctl  = wr & hit_sctl;

    wire [31:0] stat_word = {27'h0, tx_valid, ~fifo_full_n, busy_r,
                             scl_filt, sda_filt};
    // unmapped addresses read as zero
    wire [31:0] rd_mux = hit_mctl ? mctl_pack(mctl_r) :
                         hit_sctl ? sctl_pack(sctl_r) :
                         hit_stat ? stat_word : 32'h0000_0000;

    // a write in the eot cycle wins so a new transfer is not lost
    wire tx_en_nxt = wr_mctl ? wdata[IDFSS_TXEN_BIT] :
                     (dma_tx_eot ? 1'b0 : mctl_r.tx_dma_en);
    wire rx_en_nxt = wr_mctl ? wdata[IDFSS_RXEN_BIT] :
                     (dma_rx_eot ? 1'b0 : mctl_r.rx_dma_en);

    // ==========================================================
    // control registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mctl_r <= '0;
        end else begin
            mctl_r.tx_dma_en <= tx_en_nxt;
            mctl_r.rx_dma_en <= rx_en_nxt;
            if (wr_mctl) begin
                mctl_r.line_filter_select <=
                    wdata[IDFSS_FILT_LSB+:2];
                mctl_r.force_stop_request <= wdata[IDFSS_FSTOP_BIT];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sctl_r.own_address_low   <= IDFSS_ALO_RST;
            sctl_r.own_address_high  <= '0;
            sctl_r.slave_setup_delay <= IDFSS_SETUP_RST;
        end else if (wr_sctl) begin
            sctl_r.own_address_low   <= wdata[IDFSS_ALO_LSB+:7];
            sctl_r.own_address_high  <= wdata[IDFSS_AHI_LSB+:3];
            sctl_r.slave_setup_delay <= wdata[IDFSS_SETUP_LSB+:16];
        end
    end

    // read data stand one cycle only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= '0;
            fstop_r <= 1'b0;
            rxreq_r <= 1'b0;
        end else begin
            rdata_r <= rd ? rd_mux : 32'h0000_0000;
            fstop_r <= wr_mctl & wdata[IDFSS_FSTOP_BIT];
            rxreq_r <= mctl_r.rx_dma_en & rx_pending;
        end
    end

    // ==========================================================
    // transmit data path
    idfss_fifo #(
        .W (IDFSS_DATA_W),
        .D (IDFSS_FIFO_D)
    ) u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (dma_tx_valid & mctl_r.tx_dma_en),
        .in_ready  (fifo_full_n),
        .in_data   (dma_tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    // ==========================================================
    // pin synchronisers and spike filters
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
        end else begin
            sda_meta_r <= sda_in;
            sda_sync_r <= sda_meta_r;
            scl_meta_r <= scl_in;
            scl_sync_r <= scl_meta_r;
        end
    end

    // widths count this clock, which stands in for the kernel clock
    assign fwidth = filt_width(mctl_r.line_filter_select);

    idfss_glitch u_sda_filt (
        .clock    (clock),
        .reset_n  (reset_n),
        .width    (fwidth),
        .line_in  (sda_sync_r),
        .line_out (sda_filt)
    );

    idfss_glitch u_scl_filt (
        .clock    (clock),
        .reset_n  (reset_n),
        .width    (fwidth),
        .line_in  (scl_sync_r),
        .line_out (scl_filt)
    );

    // ==========================================================
    // slave data setup delay
    wire [15:0] su_val   = sctl_r.slave_setup_delay;
    wire        su_short = (su_val <= 16'h0001);
    wire        su_last  = (su_r == IDFSS_SU_COUNT) &&
                           (su_cnt_r == 16'h0001);

    // a new release restarts the wait
    always_comb begin
        su_nxt     = su_r;
        su_cnt_nxt = su_cnt_r;
        case (su_r)
            IDFSS_SU_IDLE: begin
                if (stretch_release && !su_short) begin
                    su_nxt     = IDFSS_SU_COUNT;
                    su_cnt_nxt = su_val - 16'h0001;
                end
            end
            IDFSS_SU_COUNT: begin
                if (stretch_release && !su_short) begin
                    su_cnt_nxt = su_val - 16'h0001;
                end else if (stretch_release || su_last) begin
                    su_nxt     = IDFSS_SU_IDLE;
                end else begin
                    su_cnt_nxt = su_cnt_r - 16'h0001;
                end
            end
            default: begin
                su_nxt = IDFSS_SU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            su_r     <= IDFSS_SU_IDLE;
            su_cnt_r <= '0;
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
        end else begin
            su_r     <= su_nxt;
            su_cnt_r <= su_cnt_nxt;
            busy_r   <= (su_nxt == IDFSS_SU_COUNT);
            done_r   <= (su_last && !stretch_release) ||
                        (stretch_release && su_short);
        end
    end

    // ==========================================================
    // outputs
    assign rdata        = rdata_r;
    assign dma_tx_ready = fifo_full_n;
    assign dma_tx_req   = mctl_r.tx_dma_en;
    assign dma_rx_req   = rxreq_r;
    assign force_stop   = fstop_r;
    assign own_address  = {sctl_r.own_address_high,
                           sctl_r.own_address_low};
    assign setup_busy   = busy_r;
    assign setup_done   = done_r;

    // ==========================================================
    // checks
    logic [15:0] su_age_r;
    logic [15:0] su_len_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            su_age_r <= '0;
            su_len_r <= '0;
        end else if (stretch_release) begin
            su_age_r <= 16'h0001;
            su_len_r <= su_short ? 16'h0001 : su_val;
        end else if (su_age_r != 16'hffff) begin
            su_age_r <= su_age_r + 16'h0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_tx_eot_clear: assert property (
        dma_tx_eot && !wr_mctl |=> !dma_tx_req [*2] or
        (!dma_tx_req ##1 $past(wr_mctl)))
        else $error("tx dma enable not cleared by eot");

    chk_rx_eot_clear: assert property (
        dma_rx_eot && !wr_mctl |=> !mctl_r.rx_dma_en ##1 !dma_rx_req)
        else $error("rx dma enable not cleared by eot");

    chk_rx_req_gate: assert property (
        dma_rx_req |-> $past(mctl_r.rx_dma_en) && $past(rx_pending))
        else $error("rx request without enable");

    chk_filt_readback: assert property (
        wr_mctl ##1 (rd && hit_mctl) |=>
        rdata[IDFSS_FILT_LSB+:2] == $past(wdata[IDFSS_FILT_LSB+:2], 2))
        else $error("filter select readback wrong");

    chk_no_filter: assert property (
        mctl_r.line_filter_select == 2'h0 && sda_sync_r != sda_filt
        |=> sda_filt == $past(sda_sync_r))
        else $error("unfiltered line did not follow");

    chk_spike_drop: assert property (
        (mctl_r.line_filter_select == 2'h1 && scl_sync_r == scl_filt)
        ##1 (mctl_r.line_filter_select == 2'h1 && scl_sync_r != scl_filt)
        ##1 (scl_sync_r == $past(scl_sync_r, 2))
        |-> $stable(scl_filt) ##1 $stable(scl_filt))
        else $error("one clock spike passed the filter");

    chk_force_stop: assert property (
        wr_mctl && wdata[IDFSS_FSTOP_BIT] && !$past(wr)
        |=> force_stop ##1 !force_stop)
        else $error("force stop pulse wrong");

    chk_addr_readback: assert property (
        wr_sctl ##1 (rd && hit_sctl) |=>
        rdata[9:0] == $past(wdata[9:0], 2) &&
        own_address == $past(wdata[9:0], 2))
        else $error("own address not held");

    chk_setup_wait: assert property (
        setup_done |-> su_age_r == su_len_r)
        else $error("setup delay length wrong");

    chk_setup_busy: assert property (
        setup_busy |-> su_age_r < su_len_r)
        else $error("setup wait overran its length");

    chk_addr_hold: assert property (
        !wr_sctl |=> $stable(own_address))
        else $error("own address moved without a write");

    chk_fstop_idle: assert property (
        !(wr_mctl && wdata[IDFSS_FSTOP_BIT]) |=> !force_stop)
        else $error("force stop without a write of one");

    cov_tx_eot: cover property (dma_tx_req ##1 dma_tx_eot ##1 !dma_tx_req);
    cov_spike: cover property (
        mctl_r.line_filter_select == 2'h3 && sda_sync_r != sda_filt
        ##1 sda_sync_r == sda_filt);
    cov_setup: cover property (setup_busy ##1 setup_done);
    cov_full: cover property (!dma_tx_ready && dma_tx_req);
    cov_rx_eot: cover property (dma_rx_req ##1 dma_rx_eot);
endmodule
